// file: design/tcf_defs.vh
`ifndef TCF_DEFS_VH
`define TCF_DEFS_VH

// Register page and addresses
`define TCF_PAGE            8'h00
`define TCF_ADDR_CONTROL    8'h91
`define TCF_ADDR_RELOAD_LO  8'h92
`define TCF_ADDR_RELOAD_HI  8'h93
`define TCF_ADDR_COUNT_LO   8'h94
`define TCF_ADDR_COUNT_HI   8'h95

// Control register field positions
`define TCF_BIT_HIGH_FLAG   7
`define TCF_BIT_LOW_FLAG    6
`define TCF_BIT_LOW_IRQ_EN  5
`define TCF_BIT_CAPTURE_EN  4
`define TCF_BIT_SPLIT_EN    3
`define TCF_BIT_RUN         2
`define TCF_BIT_CLKSEL_HI   1
`define TCF_BIT_CLKSEL_LO   0

// Reset values
`define TCF_CONTROL_RESET   8'h00
`define TCF_BYTE_RESET      8'h00

// Alternative clock select codes
`define TCF_CLKSEL_DIV12    2'h0
`define TCF_CLKSEL_EXT8     2'h1
`define TCF_CLKSEL_RSVD     2'h2
`define TCF_CLKSEL_RTC      2'h3

// Byte limits
`define TCF_BYTE_MAX        8'hff

// System clock divide-by-12 prescaler
`define TCF_DIV12_LAST      4'hb
`define TCF_DIV12_ZERO      4'h0

`endif

// file: design/tcf_byte_counter.v
`timescale 1ns/1ps
`default_nettype none
`include "tcf_defs.vh"

// One 8-bit count byte with load and increment
module tcf_byte_counter (
	input  wire       clk_in,
	input  wire       rst_n_in,
	input  wire       load_in,
	input  wire [7:0] load_val_in,
	input  wire       inc_in,
	output wire [7:0] count_out,
	output wire       wrap_out
);

	reg [7:0] count_r;
	reg [7:0] count_nxt;

	// Load has priority over counting
	always @* begin
		count_nxt = count_r;
		if (load_in)
			count_nxt = load_val_in;
		else if (inc_in)
			count_nxt = count_r + 8'h01;
	end

	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			count_r <= `TCF_BYTE_RESET;
		else
			count_r <= count_nxt;
	end

	assign count_out = count_r;
	// Roll from all ones to zero on this increment
	assign wrap_out  = inc_in & (count_r == `TCF_BYTE_MAX);

endmodule // tcf_byte_counter

`default_nettype wire

// file: design/tcf_timer3.v
`timescale 1ns/1ps
`default_nettype none
`include "tcf_defs.vh"

// How it works
// - High byte rollover to zero, or full 16-bit wrap, sets high_overflow_flag.
// - With timer interrupt enabled, a set high flag requests an interrupt.
// - Low byte rollover sets low_overflow_flag in every mode.
// - Hardware never clears the flags; only software writes zero.
// - Low flag requests interrupt only when low_byte_irq_enable and timer interrupt enabled.
// - capture_mode_enable one selects period capture; zero keeps normal timing.
// - Control register at page 0x0, address 0x91, all bits read/write, reset zero.
// - Bit 3 is split_mode_enable, choosing 16-bit or dual 8-bit operation.
// - Split zero gives one 16-bit reload counter; one gives two 8-bit ones.
// - run_control enables counting; in split mode it gates only the high byte.
// - alt_clock_select picks alternative clock and capture trigger per code.
// - Capture event copies count into reload pair and sets high flag.
module tcf_timer3 (
	input  wire       sys_clk_in,
	input  wire       rst_n_in,
	input  wire [7:0] sfr_page_in,
	input  wire [7:0] sfr_addr_in,
	input  wire       sfr_wr_in,
	input  wire [7:0] sfr_wdata_in,
	input  wire       sfr_rd_in,
	output reg  [7:0] sfr_rdata_out,
	input  wire       timer_irq_enable_in,
	input  wire       high_use_system_clock_in,
	input  wire       low_use_system_clock_in,
	input  wire       ext_osc_div8_tick_in,
	input  wire       rtc_tick_in,
	output reg        irq_req_out
);

	reg        rst_meta_r;
	reg        rst_sync_r;
	reg        high_flag_r;
	reg        low_flag_r;
	reg        low_irq_en_r;
	reg        capture_en_r;
	reg        split_en_r;
	reg        run_r;
	reg  [1:0] clksel_r;
	reg  [7:0] reload_lo_r;
	reg  [7:0] reload_hi_r;
	reg  [3:0] div12_r;
	reg        div12_tick_r;
	reg        ext_tick;
	reg        cap_tick;
	reg  [7:0] rdata_nxt;

	wire       rst_n;
	wire       page_hit;
	wire       wr_ctl;
	wire       wr_rl_lo;
	wire       wr_rl_hi;
	wire       wr_cnt_lo;
	wire       wr_cnt_hi;
	wire       low_tick;
	wire       high_tick;
	wire       inc_lo;
	wire       inc_hi;
	wire       wrap_lo;
	wire       wrap_hi;
	wire       wrap16;
	wire       reload16;
	wire       capture_evt;
	wire       set_high;
	wire       set_low;
	wire       load_lo;
	wire       load_hi;
	wire [7:0] load_lo_val;
	wire [7:0] load_hi_val;
	wire [7:0] count_lo;
	wire [7:0] count_hi;
	wire [7:0] control_val;

	// Reset released through two flops so release is clean
	always @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end
	assign rst_n = rst_sync_r;

	// Register decode
	assign page_hit  = (sfr_page_in == `TCF_PAGE);
	assign wr_ctl    = sfr_wr_in & page_hit & (sfr_addr_in == `TCF_ADDR_CONTROL);
	assign wr_rl_lo  = sfr_wr_in & page_hit & (sfr_addr_in == `TCF_ADDR_RELOAD_LO);
	assign wr_rl_hi  = sfr_wr_in & page_hit & (sfr_addr_in == `TCF_ADDR_RELOAD_HI);
	assign wr_cnt_lo = sfr_wr_in & page_hit & (sfr_addr_in == `TCF_ADDR_COUNT_LO);
	assign wr_cnt_hi = sfr_wr_in & page_hit & (sfr_addr_in == `TCF_ADDR_COUNT_HI);

	// System clock divided by 12 as a one-cycle enable
	always @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			div12_r      <= `TCF_DIV12_ZERO;
			div12_tick_r <= 1'b0;
		end else begin
			div12_tick_r <= (div12_r == `TCF_DIV12_LAST);
			if (div12_r == `TCF_DIV12_LAST)
				div12_r <= `TCF_DIV12_ZERO;
			else
				div12_r <= div12_r + 4'h1;
		end
	end

	// Alternative clock and capture trigger; reserved code never ticks
	always @* begin
		ext_tick = 1'b0;
		cap_tick = 1'b0;
		case (clksel_r)
			`TCF_CLKSEL_DIV12: begin
				ext_tick = div12_tick_r;
				cap_tick = rtc_tick_in;
			end
			`TCF_CLKSEL_EXT8: begin
				ext_tick = ext_osc_div8_tick_in;
				cap_tick = ext_osc_div8_tick_in;
			end
			`TCF_CLKSEL_RTC: begin
				ext_tick = rtc_tick_in;
				cap_tick = ext_osc_div8_tick_in;
			end
			default: begin
				ext_tick = 1'b0;
				cap_tick = 1'b0;
			end
		endcase
	end

	// Per-byte tick: system clock or the alternative clock
	assign low_tick  = low_use_system_clock_in | ext_tick;
	assign high_tick = high_use_system_clock_in | ext_tick;

	// Increment enables; split low byte ignores run control
	assign inc_lo = split_en_r ? low_tick : (run_r & low_tick);
	assign inc_hi = split_en_r ? (run_r & high_tick) : (run_r & low_tick & wrap_lo);

	// Full wrap reloads both bytes except in capture mode, where the count rolls on to zero
	assign wrap16      = ~split_en_r & wrap_hi;
	assign reload16    = wrap16 & ~capture_en_r;
	assign capture_evt = capture_en_r & cap_tick;

	// Software write beats counting; split bytes reload on their own wrap
	assign load_lo     = wr_cnt_lo | reload16 | (split_en_r & wrap_lo);
	assign load_hi     = wr_cnt_hi | reload16 | (split_en_r & wrap_hi);
	assign load_lo_val = wr_cnt_lo ? sfr_wdata_in : reload_lo_r;
	assign load_hi_val = wr_cnt_hi ? sfr_wdata_in : reload_hi_r;

	// Low byte; in 16-bit mode it rolls to zero and carries, but reloads on a full wrap outside capture mode
	tcf_byte_counter u_low (
		.clk_in      (sys_clk_in),
		.rst_n_in    (rst_n),
		.load_in     (load_lo),
		.load_val_in (load_lo_val),
		.inc_in      (inc_lo),
		.count_out   (count_lo),
		.wrap_out    (wrap_lo)
	);

	// High byte
	tcf_byte_counter u_high (
		.clk_in      (sys_clk_in),
		.rst_n_in    (rst_n),
		.load_in     (load_hi),
		.load_val_in (load_hi_val),
		.inc_in      (inc_hi),
		.count_out   (count_hi),
		.wrap_out    (wrap_hi)
	);

	// Flag set events
	assign set_high = wrap_hi | capture_evt;
	assign set_low  = wrap_lo;

	// Control register; hardware set outranks a software clear
	always @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			high_flag_r  <= 1'b0;
			low_flag_r   <= 1'b0;
			low_irq_en_r <= 1'b0;
			capture_en_r <= 1'b0;
			split_en_r   <= 1'b0;
			run_r        <= 1'b0;
			clksel_r     <= 2'h0;
		end else begin
			if (set_high)
				high_flag_r <= 1'b1;
			else if (wr_ctl)
				high_flag_r <= sfr_wdata_in[`TCF_BIT_HIGH_FLAG];
			if (set_low)
				low_flag_r <= 1'b1;
			else if (wr_ctl)
				low_flag_r <= sfr_wdata_in[`TCF_BIT_LOW_FLAG];
			if (wr_ctl) begin
				low_irq_en_r <= sfr_wdata_in[`TCF_BIT_LOW_IRQ_EN];
				capture_en_r <= sfr_wdata_in[`TCF_BIT_CAPTURE_EN];
				split_en_r   <= sfr_wdata_in[`TCF_BIT_SPLIT_EN];
				run_r        <= sfr_wdata_in[`TCF_BIT_RUN];
				clksel_r     <= sfr_wdata_in[`TCF_BIT_CLKSEL_HI:`TCF_BIT_CLKSEL_LO];
			end
		end
	end

	// Reload pair; capture overwrites, a same-cycle software write loses
	always @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			reload_lo_r <= `TCF_BYTE_RESET;
			reload_hi_r <= `TCF_BYTE_RESET;
		end else if (capture_evt) begin
			reload_lo_r <= count_lo;
			reload_hi_r <= count_hi;
		end else begin
			if (wr_rl_lo)
				reload_lo_r <= sfr_wdata_in;
			if (wr_rl_hi)
				reload_hi_r <= sfr_wdata_in;
		end
	end

	assign control_val = {high_flag_r, low_flag_r, low_irq_en_r, capture_en_r,
		split_en_r, run_r, clksel_r};

	// Read mux; unmapped addresses read zero
	always @* begin
		rdata_nxt = 8'h00;
		if (sfr_rd_in && page_hit) begin
			case (sfr_addr_in)
				`TCF_ADDR_CONTROL:   rdata_nxt = control_val;
				`TCF_ADDR_RELOAD_LO: rdata_nxt = reload_lo_r;
				`TCF_ADDR_RELOAD_HI: rdata_nxt = reload_hi_r;
				`TCF_ADDR_COUNT_LO:  rdata_nxt = count_lo;
				`TCF_ADDR_COUNT_HI:  rdata_nxt = count_hi;
				default:             rdata_nxt = 8'h00;
			endcase
		end
	end

	// Registered outputs; request is a level while an enabled flag is pending
	always @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			sfr_rdata_out <= 8'h00;
			irq_req_out   <= 1'b0;
		end else begin
			sfr_rdata_out <= rdata_nxt;
			irq_req_out   <= timer_irq_enable_in &
				(high_flag_r | (low_flag_r & low_irq_en_r));
		end
	end

endmodule // tcf_timer3

`default_nettype wire

// file: verif/tcf_timer3_properties.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the timer control register
module tcf_props (
	input wire logic       sys_clk_in,
	input wire logic       rst_n_in,
	input wire logic [7:0] sfr_page_in,
	input wire logic [7:0] sfr_addr_in,
	input wire logic       sfr_wr_in,
	input wire logic [7:0] sfr_wdata_in,
	input wire logic       sfr_rd_in,
	input wire logic [7:0] sfr_rdata_out,
	input wire logic       timer_irq_enable_in,
	input wire logic       high_use_system_clock_in,
	input wire logic       low_use_system_clock_in,
	input wire logic       ext_osc_div8_tick_in,
	input wire logic       rtc_tick_in,
	input wire logic       irq_req_out
);
	logic on_c;
	logic rd_c;
	// Plain control read, no write beside it, so no software write can move the flags under it
	assign on_c = sfr_page_in == 8'h00 && sfr_addr_in == 8'h91;
	assign rd_c = sfr_rd_in && on_c && !sfr_wr_in;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	a_idle_rdata_zero: assert property (!sfr_rd_in |=> sfr_rdata_out == 8'h00)
		else $error("idle read data");
	a_bad_page: assert property (sfr_rd_in && sfr_page_in != 8'h00 |=> sfr_rdata_out == 8'h00)
		else $error("other page answered");
	a_bad_addr: assert property (sfr_rd_in && (sfr_addr_in < 8'h91 || sfr_addr_in > 8'h95) |=> !sfr_rdata_out)
		else $error("unmapped address answered");
	a_ctrl_bits_rw: assert property (sfr_wr_in && on_c ##1 !sfr_wr_in ##1 rd_c |=>
		((sfr_rdata_out ^ $past(sfr_wdata_in, 3)) & 8'h3f) == 8'h00) else $error("control bits lost");
	a_high_sticky: assert property (rd_c ##1 !sfr_wr_in && sfr_rdata_out[7] ##1 rd_c |=> sfr_rdata_out[7])
		else $error("high flag cleared");
	a_low_sticky: assert property (rd_c ##1 !sfr_wr_in && sfr_rdata_out[6] ##1 rd_c |=> sfr_rdata_out[6])
		else $error("low flag cleared");
	a_irq_gated: assert property (!timer_irq_enable_in |=> !irq_req_out)
		else $error("request while disabled");
	a_irq_cause: assert property (rd_c && timer_irq_enable_in |=>
		irq_req_out == (sfr_rdata_out[7] || (sfr_rdata_out[6] && sfr_rdata_out[5]))) else $error("request mismatch");
endmodule // tcf_props
`default_nettype wire

// file: verif/test_timer3_control_flags.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, ac) begin n_tests++; if ((ac) !== (ex)) begin err_count++; \
	$display("Error %s expected %h seen %h", nm, ex, ac); end end
module test_timer3_control_flags;
	logic       sys_clk_in, rst_n_in, sfr_wr_in, sfr_rd_in, timer_irq_enable_in, high_use_system_clock_in;
	logic       low_use_system_clock_in, ext_osc_div8_tick_in, rtc_tick_in;
	logic [7:0] sfr_page_in, sfr_addr_in, sfr_wdata_in, d;
	wire  [7:0] sfr_rdata_out;
	wire        irq_req_out;
	int         err_count, n_tests, cyc;
	logic [1:0] codes [3] = '{2'h0, 2'h1, 2'h3};
	tcf_timer3 uut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .sfr_page_in(sfr_page_in),
		.sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in), .sfr_wdata_in(sfr_wdata_in), .sfr_rd_in(sfr_rd_in),
		.sfr_rdata_out(sfr_rdata_out), .timer_irq_enable_in(timer_irq_enable_in),
		.high_use_system_clock_in(high_use_system_clock_in), .low_use_system_clock_in(low_use_system_clock_in),
		.ext_osc_div8_tick_in(ext_osc_div8_tick_in), .rtc_tick_in(rtc_tick_in), .irq_req_out(irq_req_out));
	// 40 MHz clock
	initial begin
		sys_clk_in = 1'b0;
		forever #12.5 sys_clk_in = ~sys_clk_in;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge sys_clk_in);
		sfr_addr_in <= a;
		sfr_wdata_in <= v;
		sfr_wr_in <= 1'b1;
		@(posedge sys_clk_in);
		sfr_wr_in <= 1'b0;
	endtask
	// Read data is registered, so take it a half cycle after the taking edge
	task automatic rd(input logic [7:0] a);
		@(posedge sys_clk_in);
		sfr_addr_in <= a;
		sfr_rd_in <= 1'b1;
		@(posedge sys_clk_in);
		sfr_rd_in <= 1'b0;
		@(negedge sys_clk_in);
		d = sfr_rdata_out;
	endtask
	task automatic pulse(input logic [1:0] v);
		@(posedge sys_clk_in);
		{rtc_tick_in, ext_osc_div8_tick_in} <= v;
		@(posedge sys_clk_in);
		{rtc_tick_in, ext_osc_div8_tick_in} <= 2'b00;
	endtask
	task automatic t_regs;
		for (int a = 'h91; a <= 'h95; a++) begin
			rd(8'(a));
			`CHK("reset value", 8'h00, d)
		end
		wr(8'h91, 8'h2b);
		rd(8'h91);
		`CHK("control", 8'h2b, d)
		@(posedge sys_clk_in) sfr_page_in <= 8'h01;
		wr(8'h91, 8'h00);
		rd(8'h91);
		`CHK("other page", 8'h00, d)
		@(posedge sys_clk_in) sfr_page_in <= 8'h00;
		rd(8'h91);
		`CHK("control kept", 8'h2b, d)
		rd(8'h90);
		`CHK("unmapped", 8'h00, d)
		wr(8'h91, 8'h00);
		$display("regs done");
	endtask
	// Full 16-bit wrap must reload and raise both flags
	task automatic t_wide;
		wr(8'h92, 8'h34);
		wr(8'h93, 8'h12);
		wr(8'h94, 8'hfd);
		wr(8'h95, 8'hff);
		wr(8'h91, 8'h04);
		repeat (8) @(posedge sys_clk_in);
		rd(8'h91);
		`CHK("wrap flags", 8'hc4, d)
		`CHK("irq", 1'b1, irq_req_out)
		rd(8'h95);
		`CHK("reload high", 8'h12, d)
		wr(8'h91, 8'hc0);
		repeat (4) @(posedge sys_clk_in);
		rd(8'h91);
		rd(8'h91);
		`CHK("flags kept", 8'hc0, d)
		@(posedge sys_clk_in) timer_irq_enable_in <= 1'b0;
		repeat (2) @(negedge sys_clk_in);
		`CHK("irq masked", 1'b0, irq_req_out)
		@(posedge sys_clk_in) timer_irq_enable_in <= 1'b1;
		wr(8'h91, 8'h00);
		rd(8'h91);
		`CHK("flags cleared", 8'h00, d)
		`CHK("irq gone", 1'b0, irq_req_out)
		$display("wide done");
	endtask
	// Low byte runs with run control off; high byte must hold
	task automatic t_split;
		wr(8'h94, 8'hfe);
		wr(8'h95, 8'h55);
		wr(8'h91, 8'h08);
		repeat (6) @(posedge sys_clk_in);
		rd(8'h91);
		rd(8'h91);
		`CHK("split low flag", 8'h48, d)
		`CHK("no low irq", 1'b0, irq_req_out)
		rd(8'h95);
		`CHK("high held", 8'h55, d)
		wr(8'h91, 8'h68);
		repeat (2) @(negedge sys_clk_in);
		`CHK("low irq", 1'b1, irq_req_out)
		// Clear lands on the very edge of the next low wrap: the set must win
		wr(8'h91, 8'h08);
		wr(8'h94, 8'hfe);
		wr(8'h91, 8'h08);
		rd(8'h91);
		`CHK("set beats clear", 8'h48, d)
		wr(8'h91, 8'h00);
		$display("split done");
	endtask
	// Only the trigger picked by the select code may capture
	task automatic t_cap;
		for (int i = 0; i < 3; i++) begin
			wr(8'h95, 8'h00);
			wr(8'h94, 8'h00);
			wr(8'h93, 8'haa);
			wr(8'h91, 8'h14 | codes[i]);
			pulse(codes[i][0] ? 2'b10 : 2'b01);
			rd(8'h91);
			`CHK("wrong trigger", 8'h14 | codes[i], d)
			pulse(codes[i][0] ? 2'b01 : 2'b10);
			rd(8'h91);
			`CHK("capture flag", 8'h94 | codes[i], d)
			rd(8'h93);
			`CHK("captured high", 8'h00, d)
		end
		wr(8'h91, 8'h00);
		$display("capture done");
	endtask
	// Alternative clocks: one count per tick of the selected source only
	task automatic t_alt;
		@(posedge sys_clk_in) {high_use_system_clock_in, low_use_system_clock_in} <= 2'b00;
		wr(8'h94, 8'h00);
		wr(8'h95, 8'h00);
		wr(8'h91, 8'h04);
		// Run stays on for exactly 48 edges, so any prescaler phase gives 4 ticks
		repeat (46) @(posedge sys_clk_in);
		wr(8'h91, 8'h01);
		rd(8'h94);
		`CHK("div12 count", 8'h04, d)
		wr(8'h91, 8'h05);
		repeat (3) pulse(2'b01);
		pulse(2'b10);
		rd(8'h94);
		`CHK("ext8 count", 8'h07, d)
		wr(8'h91, 8'h07);
		repeat (2) pulse(2'b10);
		pulse(2'b01);
		rd(8'h94);
		`CHK("rtc count", 8'h09, d)
		wr(8'h91, 8'h06);
		pulse(2'b11);
		wr(8'h91, 8'h00);
		repeat (30) @(posedge sys_clk_in);
		rd(8'h94);
		`CHK("idle count", 8'h09, d)
		@(posedge sys_clk_in) {high_use_system_clock_in, low_use_system_clock_in} <= 2'b11;
		$display("alt clocks done");
	endtask
	task automatic final_report;
		$display("Comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Hang guard, far above the few hundred cycles needed
	always @(posedge sys_clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_count++;
			final_report;
		end
	end
	initial begin
		{rst_n_in, sfr_wr_in, sfr_rd_in, ext_osc_div8_tick_in, rtc_tick_in} = 5'h00;
		{timer_irq_enable_in, high_use_system_clock_in, low_use_system_clock_in} = 3'h7;
		{sfr_page_in, sfr_addr_in, sfr_wdata_in} = 24'h000000;
		repeat (3) @(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		repeat (3) @(posedge sys_clk_in);
		t_regs;
		t_wide;
		t_split;
		t_cap;
		t_alt;
		final_report;
	end
endmodule // test_timer3_control_flags
bind tcf_timer3 tcf_props u_props (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .sfr_page_in(sfr_page_in),
	.sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in), .sfr_wdata_in(sfr_wdata_in), .sfr_rd_in(sfr_rd_in),
	.sfr_rdata_out(sfr_rdata_out), .timer_irq_enable_in(timer_irq_enable_in),
	.high_use_system_clock_in(high_use_system_clock_in), .low_use_system_clock_in(low_use_system_clock_in),
	.ext_osc_div8_tick_in(ext_osc_div8_tick_in), .rtc_tick_in(rtc_tick_in), .irq_req_out(irq_req_out));
`default_nettype wire
